// File: verilog/motion_lowpower_fifo_select_regs.sv
`timescale 1ns/10ps
`include "motion_regs_cfg.svh"

// Contract
// - bit 7 of low-power setup enables duty-cycled gyro; zero after reset.
// - bits 6:4 pick averaging of 1,2,4..128 samples; reset 000.
// - in low-power mode gyro filter follows averaging field, main lowpass ignored.
// - three eight-bit read/write wake thresholds, one per accelerometer axis.
// - rate queue bit 4 pushes temperature then rate X,Y,Z pairs each sample.
// - queueing continues even while the data path is in standby.
// - accel queue bit 3 pushes accel X,Y,Z pairs then temperature each sample.
// - both bits push 14 bytes: accel, temperature, rate, high byte first.
// - frame-sync flag bit 7 sets on its event, clears once read.
// - frame-sync event only when enabled, on input reaching selected level.
// - sample rate is filter rate divided by one plus eight-bit divider.
module motion_lowpower_fifo_select_regs
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // register port
   input wire motion_regs_pkg::reg_req_type reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // settings held in neighbouring registers
   input wire logic [2:0] main_lowpass_select_i,
   input wire logic [7:0] sample_rate_divider_i,
   input wire logic frame_sync_irq_enable_i,
   input wire logic frame_sync_irq_polarity_i,
   // sensor side
   input wire logic frame_sync_input_i,
   input wire logic filter_rate_tick_i,
   input wire motion_regs_pkg::sensor_sample_type sample_i,
   // gyro filter control
   output logic gyro_lp_enable_o,
   output logic gyro_lp_average_mode_o,
   output logic [2:0] gyro_filter_select_o,
   output logic [7:0] gyro_average_count_o,
   // wake comparators
   output logic [7:0] motion_wake_thresh_x_o,
   output logic [7:0] motion_wake_thresh_y_o,
   output logic [7:0] motion_wake_thresh_z_o,
   // queue storage
   output logic fifo_push_o,
   output logic [7:0] fifo_byte_o,
   output logic sample_tick_o,
   // frame-sync event
   output logic frame_sync_irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [111:0] pack_frame(input motion_regs_pkg::sensor_sample_type s,
                                               input logic accel_en, input logic rate_en);
      logic [111:0] f;
      f = `RST_FRAME;
      if (accel_en && rate_en)
      begin
         f = {s.accel_x, s.accel_y, s.accel_z, s.temp, s.rate_x, s.rate_y, s.rate_z};
      end
      else if (accel_en)
      begin
         f = {s.accel_x, s.accel_y, s.accel_z, s.temp, `FRAME_PAD};
      end
      else if (rate_en)
      begin
         f = {s.temp, s.rate_x, s.rate_y, s.rate_z, `FRAME_PAD};
      end
      return f;
   endfunction : pack_frame

   function automatic logic [3:0] frame_length(input logic accel_en, input logic rate_en);
      logic [3:0] n;
      n = `FRAME_BYTES_NONE;
      if (accel_en && rate_en)
      begin
         n = `FRAME_BYTES_BOTH;
      end
      else if (accel_en || rate_en)
      begin
         n = `FRAME_BYTES_ONE;
      end
      return n;
   endfunction : frame_length

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic lp_enable_q;
   logic [2:0] lp_avg_q;
   logic [7:0] thresh_x_q;
   logic [7:0] thresh_y_q;
   logic [7:0] thresh_z_q;
   logic queue_rate_q;
   logic queue_accel_q;
   logic sync_flag_q;
   logic sync_prev_q;
   logic sync_event;
   logic sync_read;
   logic [7:0] rdata_d;

   assign sync_read = reg_req_i.read && (reg_req_i.addr == `OFS_FRAME_SYNC_EVENT_STATUS);

   // only the documented fields take writes; reserved bits are never stored
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         lp_enable_q <= `RST_BIT;
         lp_avg_q <= `RST_AVG;
         thresh_x_q <= `RST_BYTE;
         thresh_y_q <= `RST_BYTE;
         thresh_z_q <= `RST_BYTE;
         queue_rate_q <= `RST_BIT;
         queue_accel_q <= `RST_BIT;
      end
      else if (reg_req_i.write)
      begin
         if (reg_req_i.addr == `OFS_GYRO_LOW_POWER_SETUP)
         begin
            lp_enable_q <= reg_req_i.wdata[`LP_ENABLE_BIT];
            lp_avg_q <= reg_req_i.wdata[`LP_AVG_MSB:`LP_AVG_LSB];
         end
         else if (reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_X)
         begin
            thresh_x_q <= reg_req_i.wdata;
         end
         else if (reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_Y)
         begin
            thresh_y_q <= reg_req_i.wdata;
         end
         else if (reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_Z)
         begin
            thresh_z_q <= reg_req_i.wdata;
         end
         else if (reg_req_i.addr == `OFS_QUEUE_SOURCE_SELECT)
         begin
            queue_rate_q <= reg_req_i.wdata[`QUEUE_RATE_BIT];
            queue_accel_q <= reg_req_i.wdata[`QUEUE_ACCEL_BIT];
         end
      end
   end

   always_comb
   begin
      rdata_d = `BYTE_ZERO;
      if (reg_req_i.addr == `OFS_GYRO_LOW_POWER_SETUP)
      begin
         rdata_d[`LP_ENABLE_BIT] = lp_enable_q;
         rdata_d[`LP_AVG_MSB:`LP_AVG_LSB] = lp_avg_q;
      end
      else if (reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_X)
      begin
         rdata_d = thresh_x_q;
      end
      else if (reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_Y)
      begin
         rdata_d = thresh_y_q;
      end
      else if (reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_Z)
      begin
         rdata_d = thresh_z_q;
      end
      else if (reg_req_i.addr == `OFS_QUEUE_SOURCE_SELECT)
      begin
         rdata_d[`QUEUE_RATE_BIT] = queue_rate_q;
         rdata_d[`QUEUE_ACCEL_BIT] = queue_accel_q;
      end
      else if (reg_req_i.addr == `OFS_FRAME_SYNC_EVENT_STATUS)
      begin
         rdata_d[`SYNC_FLAG_BIT] = sync_flag_q;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         reg_rdata_o <= `BYTE_ZERO;
         reg_rvalid_o <= `RST_BIT;
      end
      else
      begin
         reg_rvalid_o <= reg_req_i.read;
         if (reg_req_i.read)
         begin
            reg_rdata_o <= rdata_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame-sync event and read-to-clear flag

   // polarity one means active low, so the target level is its inverse
   assign sync_event = frame_sync_irq_enable_i && (frame_sync_input_i != sync_prev_q)
                        && (frame_sync_input_i == !frame_sync_irq_polarity_i);

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         sync_prev_q <= `RST_BIT;
         sync_flag_q <= `RST_BIT;
         frame_sync_irq_o <= `RST_BIT;
      end
      else
      begin
         sync_prev_q <= frame_sync_input_i;
         frame_sync_irq_o <= sync_event;
         // a new event in the read cycle survives, so it is never lost
         if (sync_event)
         begin
            sync_flag_q <= 1'b1;
         end
         else if (sync_read)
         begin
            sync_flag_q <= `RST_BIT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gyro filter control

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         gyro_lp_enable_o <= `RST_BIT;
         gyro_lp_average_mode_o <= `RST_BIT;
         gyro_filter_select_o <= `RST_AVG;
         gyro_average_count_o <= `AVG_BASE;
      end
      else
      begin
         gyro_lp_enable_o <= lp_enable_q;
         gyro_lp_average_mode_o <= lp_enable_q;
         gyro_filter_select_o <= lp_enable_q ? lp_avg_q : main_lowpass_select_i;
         gyro_average_count_o <= `AVG_BASE << lp_avg_q;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         motion_wake_thresh_x_o <= `RST_BYTE;
         motion_wake_thresh_y_o <= `RST_BYTE;
         motion_wake_thresh_z_o <= `RST_BYTE;
      end
      else
      begin
         motion_wake_thresh_x_o <= thresh_x_q;
         motion_wake_thresh_y_o <= thresh_y_q;
         motion_wake_thresh_z_o <= thresh_z_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample rate divider

   logic [7:0] div_count_q;
   logic sample_now;

   assign sample_now = filter_rate_tick_i && (div_count_q == sample_rate_divider_i);

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         div_count_q <= `RST_DIV_COUNT;
         sample_tick_o <= `RST_BIT;
      end
      else
      begin
         sample_tick_o <= sample_now;
         if (sample_now)
         begin
            div_count_q <= `RST_DIV_COUNT;
         end
         else if (filter_rate_tick_i)
         begin
            div_count_q <= div_count_q + `DIV_STEP;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte sequencer into the queue

   // a sample that arrives while a frame still drains is dropped whole,
   // so the queue never holds a torn frame
   motion_regs_pkg::seq_state_type seq_q;
   logic [111:0] frame_q;
   logic [3:0] left_q;
   logic [3:0] load_len;

   assign load_len = frame_length(queue_accel_q, queue_rate_q);

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         seq_q <= motion_regs_pkg::SEQ_IDLE;
         frame_q <= `RST_FRAME;
         left_q <= `RST_COUNT;
         fifo_push_o <= `RST_BIT;
         fifo_byte_o <= `BYTE_ZERO;
      end
      else
      begin
         fifo_push_o <= `RST_BIT;
         case (seq_q)
            motion_regs_pkg::SEQ_IDLE:
            begin
               // not gated by any standby state of the data paths
               if (sample_now && (load_len != `FRAME_BYTES_NONE))
               begin
                  frame_q <= pack_frame(sample_i, queue_accel_q, queue_rate_q);
                  left_q <= load_len;
                  seq_q <= motion_regs_pkg::SEQ_DRAIN;
               end
            end
            motion_regs_pkg::SEQ_DRAIN:
            begin
               fifo_push_o <= 1'b1;
               fifo_byte_o <= frame_q[111:104];
               frame_q <= {frame_q[103:0], `BYTE_ZERO};
               left_q <= left_q - `ONE_BYTE_COUNT;
               if (left_q == `ONE_BYTE_COUNT)
               begin
                  seq_q <= motion_regs_pkg::SEQ_IDLE;
               end
            end
            default:
            begin
               seq_q <= motion_regs_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

endmodule : motion_lowpower_fifo_select_regs

// File: verilog/motion_regs_cfg.svh
`ifndef MOTION_REGS_CFG_SVH
`define MOTION_REGS_CFG_SVH

// register offsets
`define OFS_GYRO_LOW_POWER_SETUP 8'h1E
`define OFS_MOTION_WAKE_THRESHOLD_X 8'h20
`define OFS_MOTION_WAKE_THRESHOLD_Y 8'h21
`define OFS_MOTION_WAKE_THRESHOLD_Z 8'h22
`define OFS_QUEUE_SOURCE_SELECT 8'h23
`define OFS_FRAME_SYNC_EVENT_STATUS 8'h36

// field positions
`define LP_ENABLE_BIT 7
`define LP_AVG_MSB 6
`define LP_AVG_LSB 4
`define QUEUE_RATE_BIT 4
`define QUEUE_ACCEL_BIT 3
`define SYNC_FLAG_BIT 7

// reset values
`define RST_BYTE 8'h00
`define RST_AVG 3'h0
`define RST_BIT 1'b0
`define RST_DIV_COUNT 8'h00
`define RST_FRAME 112'h0
`define RST_COUNT 4'h0

// frame byte counts
`define FRAME_BYTES_BOTH 4'hE
`define FRAME_BYTES_ONE 4'h8
`define FRAME_BYTES_NONE 4'h0
`define FRAME_PAD 48'h0000_0000_0000
`define BYTE_ZERO 8'h00
`define ONE_BYTE_COUNT 4'h1
`define DIV_STEP 8'h01
`define AVG_BASE 8'h01

`endif

// File: verilog/motion_regs_pkg.sv
package motion_regs_pkg;

   // one snapshot of all sensor outputs, 16 bits each
   typedef struct packed {
      logic [15:0] accel_x;
      logic [15:0] accel_y;
      logic [15:0] accel_z;
      logic [15:0] temp;
      logic [15:0] rate_x;
      logic [15:0] rate_y;
      logic [15:0] rate_z;
   } sensor_sample_type;

   // register port request
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_DRAIN = 2'b10
   } seq_state_type;

endpackage : motion_regs_pkg

// File: tb/motion_regs_assertions.sv
`timescale 1ns/10ps
`include "motion_regs_cfg.svh"
module motion_regs_checker
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // register port
   input wire motion_regs_pkg::reg_req_type reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   // neighbouring settings
   input wire logic [2:0] main_lowpass_select_i,
   input wire logic [7:0] sample_rate_divider_i,
   input wire logic frame_sync_irq_enable_i,
   input wire logic frame_sync_irq_polarity_i,
   // sensor side
   input wire logic frame_sync_input_i,
   input wire logic filter_rate_tick_i,
   input wire motion_regs_pkg::sensor_sample_type sample_i,
   // design outputs
   input wire logic gyro_lp_enable_o,
   input wire logic gyro_lp_average_mode_o,
   input wire logic [2:0] gyro_filter_select_o,
   input wire logic [7:0] gyro_average_count_o,
   input wire logic [7:0] motion_wake_thresh_x_o,
   input wire logic [7:0] motion_wake_thresh_y_o,
   input wire logic [7:0] motion_wake_thresh_z_o,
   input wire logic fifo_push_o,
   input wire logic [7:0] fifo_byte_o,
   input wire logic sample_tick_o,
   input wire logic frame_sync_irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////
   // consecutive pushes; saturates so a stuck push cannot wrap to a legal length
   logic [3:0] run_q;
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || !fifo_push_o)
         run_q <= 4'h0;
      else if (run_q != 4'hF)
         run_q <= run_q + 4'h1;
   end
   ////////////////////////////////////////
   a_read_answer: assert property (reg_req_i.read |=> reg_rvalid_o)
      else $error("read got no answer");
   a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_req_i.read))
      else $error("answer without read");
   a_lp_enable_wr: assert property (reg_req_i.write && reg_req_i.addr == `OFS_GYRO_LOW_POWER_SETUP
      |-> ##2 gyro_lp_enable_o == $past(reg_req_i.wdata[7], 2)) else $error("low power enable wrong");
   a_avg_count: assert property (gyro_lp_enable_o |-> gyro_average_count_o == (8'h01 << gyro_filter_select_o))
      else $error("average count wrong");
   a_mode_match: assert property (gyro_lp_average_mode_o == gyro_lp_enable_o)
      else $error("averaging mode differs from enable");
   a_main_path: assert property (!gyro_lp_enable_o && !$past(reset_i)
      |-> gyro_filter_select_o == $past(main_lowpass_select_i)) else $error("main filter not passed");
   a_thresh_x_wr: assert property (reg_req_i.write && reg_req_i.addr == `OFS_MOTION_WAKE_THRESHOLD_X
      |-> ##2 motion_wake_thresh_x_o == $past(reg_req_i.wdata, 2)) else $error("threshold x wrong");
   a_push_after_tick: assert property ($rose(fifo_push_o) |-> $past(sample_tick_o))
      else $error("push without sample");
   a_burst_len: assert property ($fell(fifo_push_o) |-> run_q == 4'h8 || run_q == 4'hE)
      else $error("frame length wrong");
   a_tick_cause: assert property (sample_tick_o |-> $past(filter_rate_tick_i))
      else $error("sample without rate tick");
   a_irq_cause: assert property (frame_sync_irq_o |-> $past(frame_sync_irq_enable_i)
      && $past(frame_sync_input_i) != $past(frame_sync_irq_polarity_i)) else $error("sync event uncaused");
   a_irq_event: assert property (frame_sync_irq_enable_i && $changed(frame_sync_input_i) && !$past(reset_i)
      && frame_sync_input_i != frame_sync_irq_polarity_i |-> ##1 frame_sync_irq_o) else $error("sync event missed");
endmodule : motion_regs_checker

bind motion_lowpower_fifo_select_regs motion_regs_checker checker_i (.*);

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model
(
   // clock
   input wire logic core_clk_i,
   // register port
   output motion_regs_pkg::reg_req_type reg_req_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   initial reg_req_o = '0;
   // released lines show the inverse, never a stale copy
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_req_o <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_i);
      reg_req_o <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk_i);
      reg_req_o <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk_i);
      reg_req_o <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hFF};
      @(posedge core_clk_i);
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask : rd
   task automatic lp_enter(input logic [2:0] avg);
      wr(8'h1E, {1'b1, avg, 4'h0});
   endtask : lp_enter
endmodule : host_model

// File: tb/tb_motion_lowpower_fifo_select_regs.sv
`timescale 1ns/10ps
module tb_motion_lowpower_fifo_select_regs;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   motion_regs_pkg::reg_req_type reg_req_i;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic [2:0] main_lowpass_select_i = 3'h0;
   logic [7:0] sample_rate_divider_i = 8'h00;
   logic frame_sync_irq_enable_i = 1'b0;
   logic frame_sync_irq_polarity_i = 1'b0;
   logic frame_sync_input_i = 1'b0;
   logic filter_rate_tick_i = 1'b0;
   motion_regs_pkg::sensor_sample_type sample_i = '0;
   logic gyro_lp_enable_o;
   logic gyro_lp_average_mode_o;
   logic [2:0] gyro_filter_select_o;
   logic [7:0] gyro_average_count_o;
   logic [7:0] motion_wake_thresh_x_o;
   logic [7:0] motion_wake_thresh_y_o;
   logic [7:0] motion_wake_thresh_z_o;
   logic fifo_push_o;
   logic [7:0] fifo_byte_o;
   logic sample_tick_o;
   logic frame_sync_irq_o;
   int failures = 0;
   int comparisons = 0;
   int irq_count = 0;
   int tick_count = 0;
   int tc;
   int nt;
   int ic;
   logic [7:0] got[$];
   logic [7:0] ofs[7] = '{8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h36, 8'h3A};
   logic [7:0] wv[7];
   logic [7:0] r;
   logic v;
   logic [111:0] fr;

   motion_lowpower_fifo_select_regs uut (.*);
   host_model hm (.core_clk_i(core_clk_i), .reg_req_o(reg_req_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o));

   always #4 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////
   always @(posedge core_clk_i)
   begin
      if (fifo_push_o === 1'b1)
         got.push_back(fifo_byte_o);
      if (sample_tick_o === 1'b1)
         tick_count++;
      if (frame_sync_irq_o === 1'b1)
         irq_count++;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   // reserved bits and the read-clear flag never keep written data
   function automatic logic [7:0] mask(input logic [7:0] a);
      case (a)
         8'h1E: return 8'hF0;
         8'h20, 8'h21, 8'h22: return 8'hFF;
         8'h23: return 8'h18;
         default: return 8'h00;
      endcase
   endfunction : mask

   function automatic logic [111:0] exp_frame(input motion_regs_pkg::sensor_sample_type s, input int m);
      if (m == 3)
         return s;
      return m == 1 ? {s[111:48], 48'h0} : {s[63:0], 48'h0};
   endfunction : exp_frame
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(30197));
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      for (int k = 0; k < 7; k++)
      begin
         hm.rd(ofs[k], r, v);
         chk("reset_value", 8'h00, r);
      end
      chk("avg_count_reset", 8'h01, gyro_average_count_o);
      $display("test reset done");
      for (int n = 0; n < 14; n++)
      begin
         wv[n % 7] = 8'($urandom);
         hm.wr(ofs[n % 7], wv[n % 7]);
         hm.rd(ofs[n % 7], r, v);
         chk("read_valid", 8'h01, {7'h0, v});
         chk("read_back", wv[n % 7] & mask(ofs[n % 7]), r);
      end
      chk("thresh_x", wv[1], motion_wake_thresh_x_o);
      chk("thresh_y", wv[2], motion_wake_thresh_y_o);
      chk("thresh_z", wv[3], motion_wake_thresh_z_o);
      $display("test registers done");
      for (int c = 0; c < 8; c++)
      begin
         @(posedge core_clk_i);
         main_lowpass_select_i <= 3'($urandom);
         hm.lp_enter(3'(c));
         repeat (2) @(posedge core_clk_i);
         #1;
         chk("lp_enable", 8'h01, {7'h0, gyro_lp_enable_o});
         chk("avg_count", 8'h01 << c, gyro_average_count_o);
         chk("filter_sel", 8'(c), {5'h0, gyro_filter_select_o});
         chk("avg_mode", 8'h01, {7'h0, gyro_lp_average_mode_o});
      end
      hm.wr(8'h1E, 8'h00);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("filter_main", {5'h0, main_lowpass_select_i}, {5'h0, gyro_filter_select_o});
      chk("avg_mode_off", 8'h00, {7'h0, gyro_lp_average_mode_o});
      chk("lp_enable_off", 8'h00, {7'h0, gyro_lp_enable_o});
      $display("test low power done");
      @(posedge core_clk_i);
      sample_rate_divider_i <= 8'($urandom_range(3));
      for (int m = 1; m < 4; m++)
      begin
         hm.wr(8'h23, {3'h0, m[1], m[0], 3'h0});
         @(posedge core_clk_i);
         sample_i <= 112'({$urandom, $urandom, $urandom, $urandom});
         got.delete();
         tc = tick_count;
         nt = 0;
         while (tick_count == tc && nt < 300)
         begin
            @(posedge core_clk_i);
            filter_rate_tick_i <= 1'b1;
            nt++;
            @(posedge core_clk_i);
            filter_rate_tick_i <= 1'b0;
            repeat (2) @(posedge core_clk_i);
         end
         chk("ticks_per_sample", sample_rate_divider_i + 8'h01, 8'(nt));
         repeat (20) @(posedge core_clk_i);
         chk("frame_len", m == 3 ? 8'h0E : 8'h08, 8'(got.size()));
         fr = exp_frame(sample_i, m);
         foreach (got[i]) chk("frame_byte", fr[111 - 8 * i -: 8], got[i]);
      end
      $display("test queue done");
      for (int p = 0; p < 2; p++)
      begin
         @(posedge core_clk_i);
         frame_sync_irq_polarity_i <= p[0];
         frame_sync_irq_enable_i <= 1'b1;
         frame_sync_input_i <= p[0];
         repeat (3) @(posedge core_clk_i);
         hm.rd(8'h36, r, v);
         ic = irq_count;
         @(posedge core_clk_i);
         frame_sync_input_i <= ~p[0];
         repeat (4) @(posedge core_clk_i);
         chk("sync_irq", 8'h01, 8'(irq_count - ic));
         hm.rd(8'h36, r, v);
         chk("sync_flag", 8'h80, r);
         hm.rd(8'h36, r, v);
         chk("sync_clear", 8'h00, r);
         @(posedge core_clk_i);
         frame_sync_irq_enable_i <= 1'b0;
         frame_sync_input_i <= p[0];
         @(posedge core_clk_i);
         frame_sync_input_i <= ~p[0];
         repeat (4) @(posedge core_clk_i);
         hm.rd(8'h36, r, v);
         chk("sync_off", 8'h00, r);
      end
      $display("test frame sync done");
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      failures++;
      print_verdict();
   end
endmodule : tb_motion_lowpower_fifo_select_regs
